// ===== src/flash_hold_regs.vh
// Constants for the pause, accelerate and sector map logic
`ifndef FLASH_HOLD_REGS_VH
`define FLASH_HOLD_REGS_VH
`define ADDR_W 23
`define SECT_MSB 22
`define SECT_LSB 16
`define SUB_MSB 16
`define SUB_LSB 12
`define SECT_W 7
`define SUB_W 5
`define SECT_SPAN 23'h00ffff
`define SUB_SPAN 23'h000fff
`define SUB8_SPAN 23'h001fff
`define ARRAY_END 23'h7fffff
`define ARRAY_START 23'h000000
`define PARAM_SECT_BOT 7'h00
`define PARAM_SECT_TOP 7'h7e
`define PARAM_PAIR_MSB 6
`define PARAM_PAIR_LSB 1
`define CFG_PARAM_TOP_BIT 2
`define CFG_QUAD_BIT 1
`define CFG_W 8
`define SUB8_MASK 23'h7fe000
`endif

// ===== src/sector_decode.v
// Address to sector and parameter sub-sector decoder
`include "flash_hold_regs.vh"
module sector_decode
(
	input wire [`ADDR_W-1:0] addr,
	input wire param_region_top_select,
	output wire [`SECT_W-1:0] sector_index,
	output wire [`SUB_W-1:0] sub_sector_index,
	output wire in_param_region
);
	wire [`SECT_W-1:0] sect;
	wire [`SECT_W-2:0] pair;
	localparam [`SECT_W-1:0] top_sect = `PARAM_SECT_TOP;
	localparam [`SECT_W-1:0] bot_sect = `PARAM_SECT_BOT;
	assign sect = addr[`SECT_MSB:`SECT_LSB];
	assign pair = sect[`PARAM_PAIR_MSB:`PARAM_PAIR_LSB];
	assign sub_sector_index = addr[`SUB_MSB:`SUB_LSB];
	assign sector_index = sect;
	// Bottom: sectors 0 and 1; top: the last two
	assign in_param_region = param_region_top_select ?
		(pair == top_sect[`PARAM_PAIR_MSB:`PARAM_PAIR_LSB]) :
		(pair == bot_sect[`PARAM_PAIR_MSB:`PARAM_PAIR_LSB]);
endmodule

// ===== src/spi_flash_hold_and_sector_map.v
// Pause pin, accelerated program gate and erase range decode of a serial flash
// What this block does
// - Pausing only stops the serial link; internal write, program, erase continue.
// - Pause begins at pause-pin fall when serial clock is low.
// - Pause-pin fall with clock high: pause begins at next clock fall.
// - Pause ends at pause-pin rise when serial clock is low.
// - Pause-pin rise with clock high: pause ends at next clock fall.
// - While paused, output is high impedance; input and clock ignored.
// - Chip select high during pause resets the interface logic.
// - Quad enable bit set disables the pause function entirely.
// - Elevated level on protect/accel pin selects shortened program timing.
// - Accelerated programming is ignored in quad mode.
// - Program data is cached per page; programming only clears bits.
// - Erase sets bits; by sub-sector, 64 kB sector or whole device.
// - Array is 128 sectors of 64 kB, ending at 7FFFFFh.
// - Parameter sub-sectors: 32 of 4 kB in the two parameter sectors.
// - Config bit 2 puts parameter sub-sectors at top, else bottom.
// - Config bit 1 selects quad I/O mode.
`include "flash_hold_regs.vh"
module spi_flash_hold_and_sector_map
#(
	parameter PAGE_BYTES = 256,
	parameter PAGE_AW = 8
)
(
	input wire clk,
	input wire nrst,
	input wire sck,
	input wire cs_n,
	input wire si,
	input wire hold_n,
	input wire write_protect_accel_pin,
	input wire elevated_program_level,
	input wire [`CFG_W-1:0] config_reg,
	input wire so_data,
	input wire so_drive,
	input wire op_busy,
	input wire [`ADDR_W-1:0] cmd_addr,
	input wire param_4k_erase,
	input wire param_8k_erase,
	input wire sector_erase_cmd,
	input wire bulk_erase_cmd,
	input wire page_load,
	input wire [PAGE_AW-1:0] page_load_addr,
	input wire [7:0] page_load_data,
	input wire page_reset,
	input wire page_read,
	input wire [PAGE_AW-1:0] page_read_addr,
	input wire [7:0] array_old_data,
	output reg so_out,
	output reg so_oe_n,
	output reg hold_active,
	output reg link_sck_rise,
	output reg link_sck_fall,
	output reg link_si,
	output reg interface_reset,
	output reg busy,
	output reg accelerated_program,
	output reg quad_mode,
	output reg wp_level,
	output reg [7:0] program_byte,
	output reg program_byte_valid,
	output reg erase_valid,
	output reg [`ADDR_W-1:0] erase_start,
	output reg [`ADDR_W-1:0] erase_end,
	output reg [`SECT_W-1:0] sector_index,
	output reg [`SUB_W-1:0] sub_sector_index,
	output reg in_param_region
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	reg [1:0] sck_meta;
	reg [1:0] cs_meta;
	reg [1:0] hold_meta;
	reg [1:0] si_meta;
	reg [1:0] acc_meta;
	reg [1:0] wp_meta;
	reg sck_d;
	reg hold_d;
	wire sck_s;
	wire cs_s;
	wire hold_s;
	wire sck_fall;
	wire sck_rise;
	wire hold_fall;
	wire hold_rise;
	wire quad;

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sck_meta <= 2'h0;
			cs_meta <= 2'h3;
			hold_meta <= 2'h3;
			si_meta <= 2'h0;
			acc_meta <= 2'h0;
			wp_meta <= 2'h3;
			sck_d <= 1'b0;
			hold_d <= 1'b1;
		end
		else
		begin
			sck_meta <= {sck_meta[0], sck};
			cs_meta <= {cs_meta[0], cs_n};
			hold_meta <= {hold_meta[0], hold_n};
			si_meta <= {si_meta[0], si};
			acc_meta <= {acc_meta[0], elevated_program_level};
			wp_meta <= {wp_meta[0], write_protect_accel_pin};
			sck_d <= sck_meta[1];
			hold_d <= hold_meta[1];
		end
	end

	assign sck_s = sck_meta[1];
	assign cs_s = cs_meta[1];
	assign hold_s = hold_meta[1];
	assign sck_fall = sck_d & ~sck_s;
	assign sck_rise = ~sck_d & sck_s;
	assign hold_fall = hold_d & ~hold_s;
	assign hold_rise = ~hold_d & hold_s;
	assign quad = config_reg[`CFG_QUAD_BIT];

	// ------------------------------------------------------------
	// Pause state
	// ------------------------------------------------------------
	// Sampled clock level equals the pin level at the pause edge,
	// both having passed the same two-flop delay.
	reg pend_enter;
	reg pend_exit;
	reg cs_d;

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hold_active <= 1'b0;
			pend_enter <= 1'b0;
			pend_exit <= 1'b0;
			cs_d <= 1'b1;
			interface_reset <= 1'b0;
		end
		else
		begin
			cs_d <= cs_s;
			interface_reset <= cs_s & ~cs_d & hold_active;
			if (cs_s || quad)
			begin
				hold_active <= 1'b0;
				pend_enter <= 1'b0;
				pend_exit <= 1'b0;
			end
			else if (hold_fall)
			begin
				pend_exit <= 1'b0;
				if (!sck_s)
					hold_active <= 1'b1;
				else
					pend_enter <= 1'b1;
			end
			else if (hold_rise)
			begin
				pend_enter <= 1'b0;
				if (!sck_s)
					hold_active <= 1'b0;
				else if (hold_active)
					pend_exit <= 1'b1;
			end
			else if (sck_fall)
			begin
				if (pend_enter)
					hold_active <= 1'b1;
				if (pend_exit)
					hold_active <= 1'b0;
				pend_enter <= 1'b0;
				pend_exit <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Link outputs and internal operation status
	// ------------------------------------------------------------
	// Gating uses the next pause value so no edge leaks on entry.
	wire next_gate;
	assign next_gate = cs_s | quad ? cs_s :
		(hold_fall & ~sck_s) | (pend_enter & sck_fall) | (hold_active & ~(hold_rise & ~sck_s)
		& ~(pend_exit & sck_fall));

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			so_out <= 1'b0;
			so_oe_n <= 1'b1;
			link_sck_rise <= 1'b0;
			link_sck_fall <= 1'b0;
			link_si <= 1'b0;
			busy <= 1'b0;
			accelerated_program <= 1'b0;
			quad_mode <= 1'b0;
			wp_level <= 1'b1;
		end
		else
		begin
			so_out <= so_data;
			so_oe_n <= next_gate | ~so_drive;
			link_sck_rise <= sck_rise & ~next_gate;
			link_sck_fall <= sck_fall & ~next_gate;
			if (!next_gate)
				link_si <= si_meta[1];
			busy <= op_busy;
			accelerated_program <= acc_meta[1] & ~quad;
			quad_mode <= quad;
			wp_level <= wp_meta[1];
		end
	end

	// ------------------------------------------------------------
	// Page cache and program merge
	// ------------------------------------------------------------
	// Merge by AND: a program can never turn a 0 back into a 1.
	reg [7:0] page_cache [0:PAGE_BYTES-1];
	reg [PAGE_BYTES-1:0] page_valid;
	genvar gi;
	generate
		for (gi = 0; gi < PAGE_BYTES; gi = gi + 1)
		begin : g_page
			always @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					page_valid[gi] <= 1'b0;
				else if (page_load && page_load_addr == gi)
					page_valid[gi] <= 1'b1;
				else if (page_reset)
					page_valid[gi] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge clk)
	begin
		if (page_load)
			page_cache[page_load_addr] <= page_load_data;
	end

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			program_byte <= 8'hff;
			program_byte_valid <= 1'b0;
		end
		else
		begin
			program_byte_valid <= page_read & page_valid[page_read_addr];
			if (page_read)
				program_byte <= page_valid[page_read_addr] ?
					(array_old_data & page_cache[page_read_addr]) : array_old_data;
		end
	end

	// ------------------------------------------------------------
	// Sector map and erase ranges
	// ------------------------------------------------------------
	wire [`SECT_W-1:0] dec_sect;
	wire [`SUB_W-1:0] dec_sub;
	wire dec_param;
	wire any_erase;
	reg [`ADDR_W-1:0] next_start;
	reg [`ADDR_W-1:0] next_end;

	sector_decode u_decode
	(
		.addr(cmd_addr),
		.param_region_top_select(config_reg[`CFG_PARAM_TOP_BIT]),
		.sector_index(dec_sect),
		.sub_sector_index(dec_sub),
		.in_param_region(dec_param)
	);

	assign any_erase = param_4k_erase | param_8k_erase | sector_erase_cmd | bulk_erase_cmd;

	always @*
	begin
		next_start = {dec_sect, {`SECT_LSB{1'b0}}};
		next_end = next_start | `SECT_SPAN;
		if (bulk_erase_cmd)
		begin
			next_start = `ARRAY_START;
			next_end = `ARRAY_END;
		end
		else if (param_8k_erase && dec_param)
		begin
			next_start = cmd_addr & `SUB8_MASK;
			next_end = next_start | `SUB8_SPAN;
		end
		else if (param_4k_erase && dec_param)
		begin
			next_start = cmd_addr & ~`SUB_SPAN;
			next_end = next_start | `SUB_SPAN;
		end
	end

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			erase_valid <= 1'b0;
			erase_start <= `ARRAY_START;
			erase_end <= `ARRAY_START;
			sector_index <= {`SECT_W{1'b0}};
			sub_sector_index <= {`SUB_W{1'b0}};
			in_param_region <= 1'b0;
		end
		else
		begin
			erase_valid <= any_erase;
			sector_index <= dec_sect;
			sub_sector_index <= dec_sub;
			in_param_region <= dec_param;
			if (any_erase)
			begin
				erase_start <= next_start;
				erase_end <= next_end;
			end
		end
	end
endmodule

// ===== verification/flash_hold_chk.sv
// Checker for pause, accelerate and erase behaviour at the block's ports
module flash_hold_chk
(
	input logic clk,
	input logic nrst,
	input logic cs_n,
	input logic op_busy,
	input logic busy,
	input logic hold_active,
	input logic so_oe_n,
	input logic link_sck_rise,
	input logic link_sck_fall,
	input logic interface_reset,
	input logic quad_mode,
	input logic accelerated_program,
	input logic sector_erase_cmd,
	input logic param_4k_erase,
	input logic param_8k_erase,
	input logic bulk_erase_cmd,
	input logic erase_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_pause_hiz: assert property (hold_active |-> so_oe_n)
		else $error("output driven while paused");
	a_pause_noclk: assert property (hold_active |-> !link_sck_rise && !link_sck_fall)
		else $error("clock edge passed while paused");
	a_busy_kept: assert property (hold_active && op_busy |=> busy)
		else $error("busy lost during pause");
	a_quad_nopause: assert property (quad_mode [*3] |-> !hold_active)
		else $error("pause in quad mode");
	a_quad_noaccel: assert property (quad_mode [*2] |-> !accelerated_program)
		else $error("accelerate in quad mode");
	a_erase_resp: assert property
		(sector_erase_cmd || param_4k_erase || param_8k_erase || bulk_erase_cmd |=> erase_valid)
		else $error("erase request not answered");
	a_desel_clear: assert property (hold_active && $rose(cs_n) |-> ##[1:4] !hold_active)
		else $error("pause kept after deselect");
	a_desel_reset: assert property (hold_active && $rose(cs_n) |-> ##[1:4] interface_reset)
		else $error("no interface reset");
	a_reset_pulse: assert property (interface_reset |=> !interface_reset)
		else $error("interface reset too long");
	a_desel_idle: assert property (cs_n [*6] |-> !hold_active)
		else $error("pause while deselected");
	c_pause: cover property ($rose(hold_active));
	c_ireset: cover property (interface_reset);
	c_accel: cover property (accelerated_program);
endmodule

bind spi_flash_hold_and_sector_map flash_hold_chk chk(.clk, .nrst, .cs_n, .op_busy, .busy, .hold_active,
	.so_oe_n, .link_sck_rise, .link_sck_fall, .interface_reset, .quad_mode, .accelerated_program,
	.sector_erase_cmd, .param_4k_erase, .param_8k_erase, .bulk_erase_cmd, .erase_valid);

// ===== verification/spi_host_model.sv
// Host controller model driving the serial pins
module spi_host_model
(
	input logic clk
);
	timeunit 1ns;
	timeprecision 100ps;
	logic sck = 1'b0;
	logic cs_n = 1'b1;
	logic si = 1'b0;
	logic hold_n = 1'b1;
	// Clock runs only inside frames; data toggles so stale bits never look valid
	// Start just after a falling clk edge so no pin moves on a rising one
	task automatic pulses(input int n);
		@(negedge clk);
		#1;
		repeat (n)
		begin
			#62.5 sck = 1'b1;
			#62.5 sck = 1'b0;
			si = ~si;
		end
	endtask
	task automatic select();
		@(negedge clk);
		#1 hold_n = 1'b1;
		#100 cs_n = 1'b0;
	endtask
endmodule

// ===== verification/tb_top.sv
// Testbench for the pause, accelerate, erase decode and page cache block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic write_protect_accel_pin = 1'b1, elevated_program_level = 1'b0, so_data = 1'b0, so_drive = 1'b0;
	logic op_busy = 1'b0, param_4k_erase = 1'b0, param_8k_erase = 1'b0, sector_erase_cmd = 1'b0;
	logic bulk_erase_cmd = 1'b0, page_load = 1'b0, page_reset = 1'b0, page_read = 1'b0;
	logic [7:0] config_reg = 8'h00, page_load_addr = 8'h00, page_load_data = 8'h00;
	logic [7:0] page_read_addr = 8'h00, array_old_data = 8'h00, program_byte;
	logic [22:0] cmd_addr = 23'h000000, erase_start, erase_end;
	logic so_out, so_oe_n, hold_active, link_sck_rise, link_sck_fall, link_si, interface_reset, busy;
	logic accelerated_program, quad_mode, wp_level, program_byte_valid, erase_valid, in_param_region;
	logic [6:0] sector_index;
	logic [4:0] sub_sector_index;
	int err_count = 0, total_checks = 0;
	spi_host_model host(.clk);
	spi_flash_hold_and_sector_map dut(.clk, .nrst, .sck(host.sck), .cs_n(host.cs_n), .si(host.si),
		.hold_n(host.hold_n), .write_protect_accel_pin, .elevated_program_level, .config_reg, .so_data,
		.so_drive, .op_busy, .cmd_addr, .param_4k_erase, .param_8k_erase, .sector_erase_cmd, .bulk_erase_cmd,
		.page_load, .page_load_addr, .page_load_data, .page_reset, .page_read, .page_read_addr, .array_old_data,
		.so_out, .so_oe_n, .hold_active, .link_sck_rise, .link_sck_fall, .link_si, .interface_reset, .busy,
		.accelerated_program, .quad_mode, .wp_level, .program_byte, .program_byte_valid, .erase_valid,
		.erase_start, .erase_end, .sector_index, .sub_sector_index, .in_param_region);
	always #5 clk = ~clk;
	// ----------------
	// Helpers
	// ----------------
	task automatic chk(input logic [22:0] got, input logic [22:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Pause flag lags the pin by the synchroniser, so wait a bounded while
	task automatic wait_hold(input logic v);
		for (int i = 0; i < 40 && hold_active !== v; i++)
			@(posedge clk);
		chk(hold_active, v);
		if (hold_active !== v)
			report_and_stop();
	endtask
	task automatic erase1(input int k, input logic [7:0] cfg, input logic [22:0] a, s, e);
		@(posedge clk);
		config_reg <= cfg;
		cmd_addr <= a;
		@(posedge clk);
		sector_erase_cmd <= k == 0;
		param_4k_erase <= k == 1;
		param_8k_erase <= k == 2;
		bulk_erase_cmd <= k == 3;
		@(posedge clk);
		{sector_erase_cmd, param_4k_erase, param_8k_erase, bulk_erase_cmd} <= 4'h0;
		@(posedge clk);
		chk(erase_valid, 1'b1);
		chk(erase_start, s);
		chk(erase_end, e);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_pause();
		logic v;
		@(posedge clk);
		so_data <= 1'b1;
		so_drive <= 1'b1;
		op_busy <= 1'b1;
		host.select();
		host.pulses(2);
		chk(so_oe_n, 1'b0);
		chk(so_out, 1'b1);
		host.hold_n <= 1'b0;
		wait_hold(1'b1);
		chk(so_oe_n, 1'b1);
		v = link_si;
		host.pulses(3); // select stays low
		repeat (4) @(posedge clk);
		chk(link_si, v);
		chk(busy, 1'b1);
		host.hold_n <= 1'b1;
		wait_hold(1'b0);
		$display("pause done");
	endtask
	task automatic t_late();
		host.sck <= 1'b1;
		host.hold_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(hold_active, 1'b0);
		host.sck <= 1'b0;
		wait_hold(1'b1);
		host.sck <= 1'b1;
		host.hold_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(hold_active, 1'b1);
		host.sck <= 1'b0;
		wait_hold(1'b0);
		$display("late edges done");
	endtask
	task automatic t_deselect();
		host.hold_n <= 1'b0;
		wait_hold(1'b1);
		host.cs_n <= 1'b1;
		for (int i = 0; i < 8 && interface_reset !== 1'b1; i++)
			@(posedge clk);
		chk(interface_reset, 1'b1);
		if (interface_reset !== 1'b1)
			report_and_stop();
		wait_hold(1'b0);
		host.hold_n <= 1'b1;
		#100 host.hold_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(hold_active, 1'b0);
		host.select();
		repeat (8) @(posedge clk);
		chk(hold_active, 1'b0);
		$display("deselect done");
	endtask
	task automatic t_quad();
		@(posedge clk);
		config_reg <= 8'h02;
		elevated_program_level <= 1'b1;
		repeat (4) @(posedge clk);
		host.hold_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(hold_active, 1'b0);
		chk(quad_mode, 1'b1);
		chk(accelerated_program, 1'b0);
		config_reg <= 8'h00;
		host.hold_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk(accelerated_program, 1'b1);
		elevated_program_level <= 1'b0;
		write_protect_accel_pin <= 1'b0;
		repeat (6) @(posedge clk);
		chk(accelerated_program, 1'b0);
		chk(wp_level, 1'b0);
		$display("quad done");
	endtask
	task automatic t_erase();
		erase1(0, 8'h00, 23'h123456, 23'h120000, 23'h12ffff);
		erase1(0, 8'h00, 23'h7f1234, 23'h7f0000, 23'h7fffff);
		chk(sector_index, 7'h7f);
		erase1(1, 8'h00, 23'h01f800, 23'h01f000, 23'h01ffff);
		chk(sector_index, 7'h01);
		chk(sub_sector_index, 5'h1f);
		chk(in_param_region, 1'b1);
		erase1(2, 8'h00, 23'h01f800, 23'h01e000, 23'h01ffff);
		erase1(1, 8'h00, 23'h00f123, 23'h00f000, 23'h00ffff);
		chk(sub_sector_index, 5'h0f);
		erase1(1, 8'h00, 23'h123456, 23'h120000, 23'h12ffff);
		chk(in_param_region, 1'b0);
		erase1(1, 8'h04, 23'h7e3456, 23'h7e3000, 23'h7e3fff);
		chk(in_param_region, 1'b1);
		erase1(1, 8'h04, 23'h01f800, 23'h010000, 23'h01ffff);
		chk(in_param_region, 1'b0);
		erase1(3, 8'h00, 23'h001234, 23'h000000, 23'h7fffff);
		$display("erase done");
	endtask
	task automatic t_page();
		@(posedge clk);
		page_load <= 1'b1;
		page_load_addr <= 8'hff;
		page_load_data <= 8'h0f;
		@(posedge clk);
		page_load <= 1'b0;
		page_read <= 1'b1;
		page_read_addr <= 8'hff;
		array_old_data <= 8'h3c;
		@(posedge clk);
		page_read <= 1'b0;
		@(posedge clk);
		chk(program_byte, 8'h0c);
		chk(program_byte_valid, 1'b1);
		page_reset <= 1'b1;
		@(posedge clk);
		page_reset <= 1'b0;
		page_read <= 1'b1;
		@(posedge clk);
		page_read <= 1'b0;
		@(posedge clk);
		chk(program_byte, 8'h3c);
		chk(program_byte_valid, 1'b0);
		$display("page done");
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_pause();
		t_late();
		t_deselect();
		t_quad();
		t_erase();
		t_page();
		report_and_stop();
	end
endmodule
